// file: rtl/swp_pkg.sv
// Purpose: shared constants and types for the serial wiper setting port
// Assumes: ref_clk at 25 MHz
// Notes:   all timing counts derive from the printed times
package swp_pkg;
	// wiper and frame layout
	localparam int          SWP_DATA_W     = 8;
	localparam int          SWP_ADDR_W     = 2;
	localparam logic        SWP_START_BIT  = 1'b1;
	localparam logic        SWP_ADDR_FIRST = 1'b1;
	localparam logic        SWP_ADDR_SECOND = 1'b0;
	localparam logic [7:0]  SWP_WIPER_RST  = 8'h00;
	localparam logic [2:0]  SWP_DATA_LAST  = 3'h7;
	localparam logic        SWP_ADDR_LAST  = 1'b1;
	// clock rate
	localparam int          SWP_REF_PERIOD_NS = 40;
	localparam int          SWP_REF_KHZ       = 25000;
	// select glitch filter: lows up to this long are ignored
	localparam int          SWP_SEL_FILT_NS  = 90;
	localparam int          SWP_SEL_FILT_CYC =
		(SWP_SEL_FILT_NS / SWP_REF_PERIOD_NS) < 1 ? 1 :
		(SWP_SEL_FILT_NS / SWP_REF_PERIOD_NS) + 1;
	// erase/write cycle time
	localparam int          SWP_BUSY_MS  = 5;
	localparam int          SWP_BUSY_CYC = SWP_BUSY_MS * SWP_REF_KHZ;
	// link frame states
	typedef enum logic [1:0] {
		SWP_IDLE = 2'b00,
		SWP_ADDR = 2'b01,
		SWP_DATA = 2'b10,
		SWP_GAP  = 2'b11
	} swp_state_t;
	// completed frame handed to the reference domain
	typedef struct packed {
		logic                  hit;
		logic [SWP_DATA_W-1:0] data;
	} swp_frame_t;
endpackage

// file: rtl/swp_sync.sv
// Purpose: three-flop input synchroniser with optional hold filter
// Assumes: din is asynchronous to clk
// Notes:   output follows once stages two and three agree for FILT cycles
`timescale 1ns/1ps
module swp_sync #(
	parameter int FILT = 1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// async in, filtered out
	input  wire logic din,
	output logic      dout
);
	logic       s1;   // first stage, read only by s2
	logic       s2;   // second stage
	logic       s3;   // third stage
	logic [7:0] cnt;  // agreement length
	// synchroniser chain
	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// accept a change only after it has stood long enough
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt  <= 8'h00;
			dout <= 1'b0;
		end else if (s2 == s3 && s3 != dout) begin
			if (cnt >= 8'(FILT - 1)) begin
				dout <= s3;
				cnt  <= 8'h00;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end else begin
			cnt <= 8'h00;
		end
	end
endmodule // swp_sync

// file: rtl/swp_nvm.sv
// Purpose: non-volatile copy of the wiper with erase/write timer
// Assumes: start is a one-cycle pulse on clk
// Notes:   rst stands for power-on; the stored copy starts at NV_INIT
`timescale 1ns/1ps
module swp_nvm
	import swp_pkg::*;
#(
	parameter int          BUSY_CYC = SWP_BUSY_CYC,
	parameter logic [7:0]  NV_INIT  = 8'h80
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// store request
	input  wire logic       start,
	input  wire logic [7:0] wdata,
	// stored value and state
	output logic [7:0]      nv_word,
	output logic            busy
);
	localparam int CW = $clog2(BUSY_CYC + 1);
	logic [CW-1:0] cnt;    // cycles left in the write
	logic [7:0]    pend;   // value being written
	// erase/write cycle, value lands at its end
	always_ff @(posedge clk) begin
		if (rst) begin
			busy    <= 1'b0;
			cnt     <= '0;
			pend    <= 8'h00;
			nv_word <= NV_INIT;
		end else if (!busy) begin
			if (start) begin
				busy <= 1'b1;
				pend <= wdata;
				cnt  <= CW'(BUSY_CYC - 1);
			end
		end else if (cnt == '0) begin
			busy    <= 1'b0;
			nv_word <= pend;
		end else begin
			cnt <= cnt - CW'(1);
		end
	end
endmodule // swp_nvm

// file: rtl/swp_port.sv
// Purpose: serial control port for an 8-bit wiper with stored backup
// Assumes: link_clk is the host serial clock, stopped between frames
// Notes:   wiper lives on ref_clk; framing runs on link_clk
// Function
// - 8-bit wiper, copy kept non-volatile
// - power-up loads wiper from stored copy
// - start bit 1, then LSB-first bits
// - sample serial_in on rising edges while selected
// - shift serial_out on the same rising edge
// - select low reloads wiper, floats serial_out
// - short select lows are filtered out; the frame sequencer still resets on any select low
// - store_request drives done flag low while busy
// - busy ignores serial_in, outputs nothing
// - low supply keeps flag high, no store
// - old value out after start and address
// - frame is start, two address, eight data
// - new setting applied after last data bit
// - ready for next frame two clocks later
// - every transfer shifts old contents out
// - unstored setting lasts while select high
// - unstored data dropped, resend before store
// - wiper address is first 1, second 0
`timescale 1ns/1ps
module swp_port
	import swp_pkg::*;
#(
	parameter int         BUSY_CYC = SWP_BUSY_CYC,
	parameter logic [7:0] NV_INIT  = 8'h80
) (
	// reference clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// serial link from the host
	input  wire logic                  link_clk,
	input  wire logic                  device_select,
	input  wire logic                  serial_in,
	input  wire logic                  store_request,
	output logic                       serial_out,
	output logic                       serial_out_oe,
	output logic                       store_done_flag,
	// supply monitor
	input  wire logic                  supply_ok,
	// wiper setting to the output stage
	output logic [SWP_DATA_W-1:0]      wiper_setting
);
	// reference domain signals
	logic                  sel_filt;   // filtered select
	logic                  store_request_s;     // synced store_request
	logic                  supply_s;   // synced supply monitor
	logic [7:0]            nv_word;    // stored copy
	logic                  busy;       // write in progress
	logic                  store_go;   // start a write
	logic                  loaded;     // power-up recall done
	logic                  f_s1;       // frame toggle stage one
	logic                  f_s2;       // frame toggle stage two
	logic                  f_s3;       // frame toggle stage three
	logic                  frame_evt;  // frame arrived
	logic [7:0]            next_wiper; // next wiper value
	logic                  wiper_tgl;  // wiper changed marker
	// link domain signals
	logic                  lr_s1;      // reset stage one
	logic                  lrst;       // link reset
	logic                  b_s1;       // busy stage one
	logic                  busy_l;     // busy on link side
	logic                  w_s1;       // wiper toggle stage one
	logic                  w_s2;       // wiper toggle stage two
	logic                  w_s3;       // wiper toggle stage three
	logic [7:0]            shadow;     // wiper copy for read-back
	swp_state_t            state;      // frame state
	logic [2:0]            cnt;        // bit counter
	logic                  addr0;      // first address bit
	logic [7:0]            in_shift;   // incoming data
	logic [7:0]            out_shift;  // outgoing old value
	logic                  frame_tgl;  // frame done marker
	swp_frame_t            frame;      // held frame contents
	logic                  addr_ok;    // second address bit matched
	logic [7:0]            rb_word;    // read-back source at address edge

	// select filter: short lows never reach the reload logic
	swp_sync #(
		.FILT (SWP_SEL_FILT_CYC)
	) u_sel (
		.clk  (ref_clk),
		.rst  (rst),
		.din  (device_select),
		.dout (sel_filt)
	);

	// store request synchroniser
	swp_sync #(
		.FILT (1)
	) u_store_request (
		.clk  (ref_clk),
		.rst  (rst),
		.din  (store_request),
		.dout (store_request_s)
	);

	// supply monitor synchroniser
	swp_sync #(
		.FILT (1)
	) u_vdd (
		.clk  (ref_clk),
		.rst  (rst),
		.din  (supply_ok),
		.dout (supply_s)
	);

	// stored copy and erase/write timer
	swp_nvm #(
		.BUSY_CYC (BUSY_CYC),
		.NV_INIT  (NV_INIT)
	) u_nvm (
		.clk     (ref_clk),
		.rst     (rst),
		.start   (store_go),
		.wdata   (frame.data),
		.nv_word (nv_word),
		.busy    (busy)
	);

	// ------------------------------------------------ reference domain

	// frame toggle crossing; data changes on the same link edge as the toggle, then holds
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			f_s1 <= 1'b0;
			f_s2 <= 1'b0;
			f_s3 <= 1'b0;
		end else begin
			f_s1 <= frame_tgl;
			f_s2 <= f_s1;
			f_s3 <= f_s2;
		end
	end
	assign frame_evt = f_s2 ^ f_s3;

	// a store starts only with a request, a hit and a good supply
	assign store_go = frame_evt && frame.hit && store_request_s
		&& supply_s && sel_filt && !busy;

	// next wiper value, reload wins over a frame
	always_comb begin
		next_wiper = wiper_setting;
		if (!loaded) begin
			next_wiper = nv_word;
		end else if (!sel_filt) begin
			next_wiper = nv_word;
		end else if (frame_evt && frame.hit) begin
			next_wiper = frame.data;
		end
	end

	// wiper register; unstored values vanish at the next reload
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wiper_setting <= SWP_WIPER_RST;
			loaded        <= 1'b0;
		end else begin
			wiper_setting <= next_wiper;
			loaded        <= 1'b1;
		end
	end

	// publish wiper changes to the link side
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wiper_tgl <= 1'b0;
		end else if (next_wiper != wiper_setting) begin
			wiper_tgl <= ~wiper_tgl;
		end
	end

	// pin control: float when deselected or while writing
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serial_out_oe   <= 1'b0;
			store_done_flag <= 1'b1;
		end else begin
			serial_out_oe   <= sel_filt && !busy;
			store_done_flag <= !busy && !store_go;
		end
	end

	// ------------------------------------------------ link domain

	// reset and busy level crossings
	always_ff @(posedge link_clk) begin
		lr_s1  <= rst;
		lrst   <= lr_s1;
		b_s1   <= busy;
		busy_l <= b_s1;
	end

	// wiper copy for read-back, taken after its toggle settles
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			w_s1   <= 1'b0;
			w_s2   <= 1'b0;
			w_s3   <= 1'b0;
			shadow <= 8'h00;
		end else begin
			w_s1 <= wiper_tgl;
			w_s2 <= w_s1;
			w_s3 <= w_s2;
			if (w_s2 != w_s3) begin
				shadow <= wiper_setting;
			end
		end
	end

	// a wiper toggle past two flops marks a settled value, so read-back
	// may take it directly even when the link clock idled beforehand
	assign rb_word = (w_s2 != w_s3) ? wiper_setting : shadow;

	// frame sequencer; dropping select ends a cut frame at once, since
	// the link clock may not run again before the next frame
	always_ff @(posedge link_clk or negedge device_select) begin
		if (!device_select) begin
			state <= SWP_IDLE;
			cnt   <= 3'h0;
			addr0 <= 1'b0;
		end else if (lrst) begin
			state <= SWP_IDLE;
			cnt   <= 3'h0;
			addr0 <= 1'b0;
		end else if (busy_l) begin
			state <= SWP_IDLE;
			cnt   <= 3'h0;
		end else begin
			case (state)
				SWP_IDLE: begin
					// zeros before a start bit are skipped
					if (serial_in == SWP_START_BIT) begin
						state <= SWP_ADDR;
						cnt   <= 3'h0;
					end
				end
				SWP_ADDR: begin
					if (cnt[0] == SWP_ADDR_LAST) begin
						state <= SWP_DATA;
						cnt   <= 3'h0;
					end else begin
						addr0 <= serial_in;
						cnt   <= cnt + 3'h1;
					end
				end
				SWP_DATA: begin
					if (cnt == SWP_DATA_LAST) begin
						state <= SWP_GAP;
					end
					cnt <= cnt + 3'h1;
				end
				SWP_GAP: begin
					// one spare edge, then ready again
					state <= SWP_IDLE;
				end
				default: begin
					state <= SWP_IDLE;
				end
			endcase
		end
	end

	// data capture, LSB first
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			in_shift <= 8'h00;
		end else if (state == SWP_DATA && device_select && !busy_l) begin
			in_shift <= {serial_in, in_shift[7:1]};
		end
	end

	// old value shifted out, loaded once the address is in
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			out_shift  <= 8'h00;
			serial_out <= 1'b0;
		end else if (busy_l) begin
			serial_out <= 1'b0;
		end else if (state == SWP_ADDR && cnt[0] == SWP_ADDR_LAST) begin
			serial_out <= rb_word[0];
			out_shift  <= {1'b0, rb_word[7:1]};
		end else if (state == SWP_DATA) begin
			serial_out <= out_shift[0];
			out_shift  <= {1'b0, out_shift[7:1]};
		end
	end

	// completed frame: capture contents and flip the marker on the same edge
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			frame     <= '0;
			frame_tgl <= 1'b0;
		end else if (state == SWP_DATA && cnt == SWP_DATA_LAST
			&& device_select && !busy_l) begin
			frame.data <= {serial_in, in_shift[7:1]};
			frame.hit  <= (addr0 == SWP_ADDR_FIRST)
				&& addr_ok;
			frame_tgl  <= ~frame_tgl;
		end
	end

	// second address bit, captured on its own edge
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			addr_ok <= 1'b0;
		end else if (state == SWP_ADDR && cnt[0] == SWP_ADDR_LAST) begin
			addr_ok <= (serial_in == SWP_ADDR_SECOND);
		end
	end
endmodule // swp_port

// file: verification/swp_port_assertions.sv
// Purpose: pin checks on the wiper setting port
// Assumes: every pin is viewed from the ref_clk domain
// Notes:   busy length is judged against BUSY_CYC
`timescale 1ns/1ps
module swp_port_assertions #(
	parameter int BUSY_CYC = 20
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// link pins
	input wire logic       link_clk,
	input wire logic       device_select,
	input wire logic       serial_in,
	input wire logic       store_request,
	input wire logic       serial_out,
	input wire logic       serial_out_oe,
	input wire logic       store_done_flag,
	// supply and wiper
	input wire logic       supply_ok,
	input wire logic [7:0] wiper_setting
);
	int unsigned busy_cnt; // sampled low cycles of the done flag
	// count the write time, cleared while ready
	always_ff @(posedge ref_clk) begin
		if (rst || store_done_flag) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_busy_min;
		$rose(store_done_flag) |-> busy_cnt >= BUSY_CYC;
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("write cycle too short");
	property p_busy_max;
		!store_done_flag |-> busy_cnt <= BUSY_CYC + 2;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("write cycle too long");
	property p_busy_oe;
		!store_done_flag && $past(!store_done_flag) |-> !serial_out_oe;
	endproperty
	a_busy_oe: assert property (p_busy_oe)
		else $error("output driven while busy");
	property p_busy_out;
		!store_done_flag && $past(!store_done_flag) |-> !serial_out;
	endproperty
	a_busy_out: assert property (p_busy_out)
		else $error("data shifted while busy");
	property p_low_supply;
		(!supply_ok && store_done_flag)[*6] |=> store_done_flag;
	endproperty
	a_low_supply: assert property (p_low_supply)
		else $error("write started on low supply");
	property p_no_request;
		(!store_request && store_done_flag)[*6] |=> store_done_flag;
	endproperty
	a_no_request: assert property (p_no_request)
		else $error("write started without request");
	property p_desel_oe;
		(!device_select)[*8] |-> ##2 !serial_out_oe;
	endproperty
	a_desel_oe: assert property (p_desel_oe)
		else $error("output still driven when deselected");
	property p_desel_hold;
		(!device_select && store_done_flag)[*8] |=> $stable(wiper_setting);
	endproperty
	a_desel_hold: assert property (p_desel_hold)
		else $error("wiper moved while deselected");
endmodule // swp_port_assertions

bind swp_port swp_port_assertions #(.BUSY_CYC(BUSY_CYC)) i_chk (
	.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
	.device_select(device_select), .serial_in(serial_in),
	.store_request(store_request), .serial_out(serial_out),
	.serial_out_oe(serial_out_oe), .store_done_flag(store_done_flag),
	.supply_ok(supply_ok), .wiper_setting(wiper_setting));

// file: verification/swp_host.sv
// Purpose: host model driving the three-wire link
// Assumes: link clock of 80 ns, stopped between frames
// Notes:   read-back sampled at the falling link edge
`timescale 1ns/1ps
module swp_host (
	// link pins to the port
	output logic      link_clk,
	output logic      device_select,
	output logic      serial_in,
	output logic      store_request,
	// read-back from the port
	input  wire logic serial_out
);
	// idle levels
	initial begin
		link_clk = 1'b0;
		device_select = 1'b0;
		serial_in = 1'b0;
		store_request = 1'b0;
	end
	// one link clock with a bit set up while low
	task automatic pulse(input logic b);
		serial_in = b;
		#40 link_clk = 1'b1;
		#40 link_clk = 1'b0;
	endtask
	// set select, then wait
	task automatic sel(input logic v, input int ns);
		device_select = v;
		#(ns);
	endtask
	// lead zeros, start, address, data, then tail clocks
	task automatic xfer(input int lead, input logic [1:0] a,
		input logic [7:0] d, input int nb, input logic st, input int tail,
		output logic [7:0] rd);
		logic [10:0] bits;
		bits = {d, a, 1'b1};
		rd = 8'h00;
		#7;
		for (int i = 0; i < lead; i++) pulse(1'b0);
		for (int i = 0; i < nb; i++) begin
			if (i == 1) store_request = st;
			pulse(bits[i]);
			if (i >= 2 && i < 10) rd[i - 2] = serial_out;
		end
		// gap clocks, kept running through a write
		for (int i = 0; i < tail; i++) pulse(1'b0);
		store_request = 1'b0;
		serial_in = ~serial_in;
	endtask
endmodule // swp_host

// file: verification/test_swp_port.sv
// Purpose: self-checking bench for the wiper setting port
// Assumes: short write time through BUSY_CYC
// Notes:   link traffic comes from the host model
`timescale 1ns/1ps
module test_swp_port;
	localparam int         BUSY = 20;
	localparam logic [7:0] NV0  = 8'h5a; // arbitrary stored copy
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic       supply_ok = 1'b1;
	logic       link_clk, device_select, serial_in, store_request;
	logic       serial_out, serial_out_oe, store_done_flag;
	logic [7:0] wiper_setting, rd;
	int         mismatches = 0, n_compared = 0, cyc = 0, n_busy = 0, n0;
	always #20 ref_clk = ~ref_clk;
	swp_port #(.BUSY_CYC(BUSY), .NV_INIT(NV0)) i_dut (.ref_clk(ref_clk),
		.rst(rst), .link_clk(link_clk), .device_select(device_select),
		.serial_in(serial_in), .store_request(store_request),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.store_done_flag(store_done_flag), .supply_ok(supply_ok),
		.wiper_setting(wiper_setting));
	swp_host i_host (.link_clk(link_clk), .device_select(device_select),
		.serial_in(serial_in), .store_request(store_request),
		.serial_out(serial_out));
	// busy cycle count and hang limit
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (!store_done_flag) n_busy <= n_busy + 1;
		if (cyc == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// reset with link edges, stored copy recalled
	task automatic t_reset;
		fork
			settle(4);
			repeat (3) i_host.pulse(1'b0);
		join
		@(negedge ref_clk) rst = 1'b0;
		settle(4);
		check(wiper_setting, NV0);
		check({7'h0, store_done_flag}, 8'h01);
	endtask
	// three frames back to back, old value checked on the first two, the third to another address
	task automatic t_write;
		i_host.sel(1'b1, 200);
		i_host.xfer(3, 2'b01, 8'h3c, 11, 1'b0, 2, rd);
		check(rd, NV0);
		settle(8);
		check(wiper_setting, 8'h3c);
		i_host.xfer(0, 2'b01, 8'hc3, 11, 1'b0, 2, rd);
		check(rd, 8'h3c);
		settle(8);
		check(wiper_setting, 8'hc3);
		i_host.xfer(0, 2'b10, 8'h11, 11, 1'b0, 2, rd);
		settle(8);
		check(wiper_setting, 8'hc3);
	endtask
	// short select glitch, then a real deselect
	task automatic t_select;
		i_host.sel(1'b0, 40);
		i_host.sel(1'b1, 400);
		check(wiper_setting, 8'hc3);
		i_host.sel(1'b0, 600);
		check(wiper_setting, NV0);
		check({7'h0, serial_out_oe}, 8'h00);
	endtask
	// store with good and with low supply
	task automatic t_store;
		i_host.sel(1'b1, 200);
		n0 = n_busy;
		i_host.xfer(0, 2'b01, 8'he1, 11, 1'b1, 16, rd);
		check(rd, NV0);
		check({7'h0, (n_busy - n0) >= BUSY}, 8'h01);
		i_host.sel(1'b0, 600);
		check(wiper_setting, 8'he1);
		@(negedge ref_clk) supply_ok = 1'b0;
		i_host.sel(1'b1, 200);
		n0 = n_busy;
		i_host.xfer(0, 2'b01, 8'h22, 11, 1'b1, 16, rd);
		check({7'h0, n_busy == n0}, 8'h01);
		i_host.sel(1'b0, 600);
		check(wiper_setting, 8'he1);
		@(negedge ref_clk) supply_ok = 1'b1;
	endtask
	// read-only poll cut before the last data bit
	// the second poll shows that the cut frame left nothing behind
	task automatic t_poll;
		repeat (2) begin
			i_host.sel(1'b1, 200);
			i_host.xfer(0, 2'b01, 8'h00, 10, 1'b0, 0, rd);
			i_host.sel(1'b0, 600);
			check(rd, 8'he1);
			check(wiper_setting, 8'he1);
		end
	endtask
	initial begin
		t_reset();
		t_write();
		t_select();
		t_store();
		t_poll();
		tally_and_finish();
	end
endmodule // test_swp_port
